// ---- inc/vlc_pkg.sv ----
/*
 * Package for the link control register bank: offsets, field positions,
 * reset values, timing counts and carrier structs.
 * Assumes one 125 MHz clock and a synchronous active-high reset.
 */
package vlc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0] VLC_ADDR_CONFIG = 4'h0;
	localparam logic [3:0] VLC_ADDR_XMIT = 4'h1;
	localparam logic [3:0] VLC_ADDR_STATUS = 4'h2;

	// Config/control fields
	localparam int VLC_CFG_TIME_BASE = 6;
	localparam int VLC_CFG_RATE_HI = 5;
	localparam int VLC_CFG_RATE_LO = 4;
	localparam int VLC_CFG_INT_EN = 1;
	localparam int VLC_CFG_WAIT_GATE = 0;
	localparam logic [7:0] VLC_CFG_RESET = 8'h00;

	// Transmit control fields
	localparam int VLC_XC_ANALOG_LOOPBACK = 7;
	localparam int VLC_XC_DIGITAL_LOOPBACK = 6;
	localparam int VLC_XC_FAST_RX = 5;
	localparam int VLC_XC_NB_FMT = 4;
	localparam int VLC_XC_EOD = 3;
	localparam int VLC_XC_SINGLE = 2;
	localparam int VLC_XC_MULTI_CRC = 1;
	localparam int VLC_XC_MULTI_PLAIN = 0;
	localparam logic [7:0] VLC_XC_RESET = 8'hC0;

	// Status fields
	localparam int VLC_ST_RATE_LOCK = 0;
	localparam int VLC_ST_RX_OK = 1;
	localparam int VLC_ST_TX_OK = 2;
	localparam int VLC_ST_TX_EMPTY = 3;

	// State vector value loaded on a received break
	localparam logic [15:0] VLC_SV_BREAK = 16'h001C;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int VLC_CLK_MHZ = 125;
	localparam int VLC_EOF_US = 280;
	localparam int VLC_IFS_US = 300;
	localparam int VLC_EOF_CYC = VLC_EOF_US * VLC_CLK_MHZ;
	localparam int VLC_IFS_CYC = VLC_IFS_US * VLC_CLK_MHZ;

	// Response request encoding
	typedef enum logic [1:0] {
		VLC_IFR_NONE,
		VLC_IFR_SINGLE,
		VLC_IFR_MULTI_CRC,
		VLC_IFR_MULTI_PLAIN
	} vlc_ifr_t;

	// Configuration seen by the protocol engine
	typedef struct packed {
		logic time_base_select;
		logic fast_receive_only;
		logic normalization_bit_crc;
		logic normalization_bit_plain;
		logic transmit_allowed;
		logic receive_allowed;
		logic end_of_data_request;
		vlc_ifr_t ifr_kind;
	} vlc_ctrl_t;

	// Events coming back from the protocol engine
	typedef struct packed {
		logic break_rx;
		logic first_crc_bit;
		logic eod_rx_valid;
		logic error;
		logic bus_idle;
		logic set_tx_empty;
	} vlc_evt_t;

endpackage

// ---- logic/vlc_link_ctrl.sv ----
/*
 * Link control register bank for a byte-oriented VPW network controller:
 * time base prescaler, interrupt gating, wait clock gating, loopback
 * routing with idle qualification, fast receive and response control.
 * Assumes a protocol engine on the same clock that supplies events and
 * digital transmit data, and a CPU port with one-cycle strobes.
 */
// Operation
// - Time base select tells symbol timing rate
// - Rate bits divide system clock 1/2/4/8
// - Rate bits writable once after reset
// - Enable gates run-mode interrupts, not wake-ups
// - Request held until all sources cleared
// - Wait gate stops clocks in wait mode
// - Analog loopback: bus not driven
// - After analog loopback, idle before traffic
// - Digital loopback routes transmit to receive
// - After digital loopback, idle before traffic
// - Fast receive: receive-only at 41.6 kbps
// - Break clears fast receive, loads vector
// - Normalization format picks NB polarity
// - End-of-data appends CRC after queued bytes
// - End-of-data clears transmit-empty at once
// - End-of-data self-clears on error, on CRC outside a response, on EOD inside one
// - Response requests priority encoded internally
// - Response requests read back as written
`timescale 1ns/1ps

module vlc_link_ctrl
	import vlc_pkg::*;
#(
	parameter int EOF_CYCLES = VLC_EOF_CYC,
	parameter int IFS_CYCLES = VLC_IFS_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire vlc_evt_t engine_evt,
	input wire logic in_ifr,
	input wire logic irq_sources,
	input wire logic wake_request,
	input wire logic cpu_wait,
	input wire logic digital_transmit_out,
	input wire logic bus_rx_pin,
	output logic digital_receive_in,
	output logic bus_tx_pin,
	output logic bus_tx_oe,
	output logic time_base_tick,
	output logic engine_clk_en,
	output logic irq_req,
	output logic sv_load,
	output logic [15:0] sv_load_value,
	output vlc_ctrl_t ctrl
);

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [3:0] a, input logic [3:0] r, input logic s);
		return s && (a == r);
	endfunction

	// Priority encode response requests, single outranks the others
	function automatic vlc_ifr_t ifr_encode(input logic [2:0] req);
		if (req[2]) begin
			return VLC_IFR_SINGLE;
		end else if (req[1]) begin
			return VLC_IFR_MULTI_CRC;
		end else if (req[0]) begin
			return VLC_IFR_MULTI_PLAIN;
		end
		return VLC_IFR_NONE;
	endfunction

	localparam int IDLE_W = $clog2(IFS_CYCLES + 1);

	logic [7:0] cfg_q, cfg_d;
	logic [7:0] xc_q, xc_d;
	logic rate_lock_q, rate_lock_d;
	logic [2:0] div_q, div_d;
	logic tick_q, tick_d;
	logic rx_meta_q, rx_sync_q;
	logic [IDLE_W-1:0] idle_cnt_q, idle_cnt_d;
	logic qual_q, qual_d;
	logic rx_ok_q, rx_ok_d;
	logic tx_ok_q, tx_ok_d;
	logic irq_q, irq_d;
	logic sv_load_q, sv_load_d;
	logic [7:0] rdata_q, rdata_d;
	logic wr_cfg, wr_xc, loop_clear, bus_level;

	assign wr_cfg = hit(reg_addr, VLC_ADDR_CONFIG, reg_wr);
	assign wr_xc = hit(reg_addr, VLC_ADDR_XMIT, reg_wr);

	// ------------------------------------------------------------
	// Configuration register
	// ------------------------------------------------------------
	// Rate bits freeze after the first write; other fields stay writable
	always_comb begin
		cfg_d = cfg_q;
		rate_lock_d = rate_lock_q;
		if (wr_cfg) begin
			cfg_d[VLC_CFG_TIME_BASE] = reg_wdata[VLC_CFG_TIME_BASE];
			cfg_d[VLC_CFG_INT_EN] = reg_wdata[VLC_CFG_INT_EN];
			cfg_d[VLC_CFG_WAIT_GATE] = reg_wdata[VLC_CFG_WAIT_GATE];
			if (!rate_lock_q) begin
				cfg_d[VLC_CFG_RATE_HI] = reg_wdata[VLC_CFG_RATE_HI];
				cfg_d[VLC_CFG_RATE_LO] = reg_wdata[VLC_CFG_RATE_LO];
				rate_lock_d = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfg_q <= VLC_CFG_RESET;
			rate_lock_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			rate_lock_q <= rate_lock_d;
		end
	end

	// ------------------------------------------------------------
	// Time base prescaler
	// ------------------------------------------------------------
	// A strobe rather than a derived clock keeps one clock tree
	always_comb begin
		logic [2:0] lim;
		lim = 3'h0;
		case ({cfg_q[VLC_CFG_RATE_HI], cfg_q[VLC_CFG_RATE_LO]})
			2'h0: lim = 3'h0;
			2'h1: lim = 3'h1;
			2'h2: lim = 3'h3;
			2'h3: lim = 3'h7;
			default: lim = 3'h0;
		endcase
		div_d = div_q;
		tick_d = 1'b0;
		if (engine_clk_en) begin
			if (div_q >= lim) begin
				div_d = 3'h0;
				tick_d = 1'b1;
			end else begin
				div_d = div_q + 3'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			div_q <= 3'h0;
			tick_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tick_q <= tick_d;
		end
	end

	assign time_base_tick = tick_q;
	// Wait gate stops the engine clock enable while the CPU waits
	assign engine_clk_en = !(cpu_wait && cfg_q[VLC_CFG_WAIT_GATE]);

	// ------------------------------------------------------------
	// Transmit control register
	// ------------------------------------------------------------
	// Hardware clears take effect unless the same cycle writes a one
	always_comb begin
		xc_d = xc_q;
		if (wr_xc) begin
			xc_d = reg_wdata;
		end
		if (engine_evt.break_rx && !(wr_xc && reg_wdata[VLC_XC_FAST_RX])) begin
			xc_d[VLC_XC_FAST_RX] = 1'b0;
		end
		if (!(wr_xc && reg_wdata[VLC_XC_EOD])) begin
			if (engine_evt.error) begin
				xc_d[VLC_XC_EOD] = 1'b0;
			end else if (in_ifr ? engine_evt.eod_rx_valid : engine_evt.first_crc_bit) begin
				xc_d[VLC_XC_EOD] = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			xc_q <= VLC_XC_RESET;
		end else begin
			xc_q <= xc_d;
		end
	end

	// ------------------------------------------------------------
	// Bus routing and loopback
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_meta_q <= 1'b1;
			rx_sync_q <= 1'b1;
		end else begin
			rx_meta_q <= bus_rx_pin;
			rx_sync_q <= rx_meta_q;
		end
	end

	// Digital loopback feeds transmit straight back, bus ignored
	assign bus_level = xc_q[VLC_XC_DIGITAL_LOOPBACK] ? digital_transmit_out : rx_sync_q;
	// Analog loopback: the transceiver loops back, its drive stays off
	assign bus_tx_oe = !xc_q[VLC_XC_ANALOG_LOOPBACK] && !xc_q[VLC_XC_DIGITAL_LOOPBACK];
	// Transceiver still needs the data in analog loop, or its echo is empty
	assign bus_tx_pin = digital_transmit_out & !xc_q[VLC_XC_DIGITAL_LOOPBACK];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			digital_receive_in <= 1'b1;
		end else begin
			digital_receive_in <= bus_level;
		end
	end

	// ------------------------------------------------------------
	// Idle qualification after loopback exit
	// ------------------------------------------------------------
	// Passive level counts as idle; any activity restarts the count
	assign loop_clear = wr_xc && ((xc_q[VLC_XC_ANALOG_LOOPBACK] && !reg_wdata[VLC_XC_ANALOG_LOOPBACK])
		|| (xc_q[VLC_XC_DIGITAL_LOOPBACK] && !reg_wdata[VLC_XC_DIGITAL_LOOPBACK]));

	always_comb begin
		idle_cnt_d = idle_cnt_q;
		qual_d = qual_q;
		rx_ok_d = rx_ok_q;
		tx_ok_d = tx_ok_q;
		if (loop_clear) begin
			qual_d = 1'b1;
			rx_ok_d = 1'b0;
			tx_ok_d = 1'b0;
			idle_cnt_d = '0;
		end else if (qual_q) begin
			if (!engine_evt.bus_idle) begin
				idle_cnt_d = '0;
			end else if (idle_cnt_q < IDLE_W'(IFS_CYCLES)) begin
				idle_cnt_d = idle_cnt_q + 1'b1;
			end
			if (idle_cnt_q >= IDLE_W'(EOF_CYCLES - 1) && engine_evt.bus_idle) begin
				rx_ok_d = 1'b1;
			end
			if (idle_cnt_q >= IDLE_W'(IFS_CYCLES - 1) && engine_evt.bus_idle) begin
				tx_ok_d = 1'b1;
				qual_d = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			idle_cnt_q <= '0;
			qual_q <= 1'b0;
			rx_ok_q <= 1'b1;
			tx_ok_q <= 1'b1;
		end else begin
			idle_cnt_q <= idle_cnt_d;
			qual_q <= qual_d;
			rx_ok_q <= rx_ok_d;
			tx_ok_q <= tx_ok_d;
		end
	end

	// ------------------------------------------------------------
	// Interrupt request and state vector load
	// ------------------------------------------------------------
	// Held while any source stays active; wake-ups bypass the enable
	always_comb begin
		irq_d = (irq_sources && cfg_q[VLC_CFG_INT_EN]) || wake_request;
		sv_load_d = engine_evt.break_rx;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_q <= 1'b0;
			sv_load_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
			sv_load_q <= sv_load_d;
		end
	end

	assign irq_req = irq_q;
	assign sv_load = sv_load_q;
	assign sv_load_value = VLC_SV_BREAK;

	// ------------------------------------------------------------
	// Control bundle to the protocol engine
	// ------------------------------------------------------------
	always_comb begin
		ctrl.time_base_select = cfg_q[VLC_CFG_TIME_BASE];
		ctrl.fast_receive_only = xc_q[VLC_XC_FAST_RX];
		ctrl.normalization_bit_crc = !xc_q[VLC_XC_NB_FMT];
		ctrl.normalization_bit_plain = xc_q[VLC_XC_NB_FMT];
		// Fast receive mode never transmits
		ctrl.transmit_allowed = tx_ok_q && !xc_q[VLC_XC_FAST_RX] && bus_tx_oe;
		ctrl.receive_allowed = rx_ok_q;
		ctrl.end_of_data_request = xc_q[VLC_XC_EOD];
		ctrl.ifr_kind = ifr_encode(xc_q[2:0]);
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// Unmapped addresses read as zero
	always_comb begin
		rdata_d = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				VLC_ADDR_CONFIG: rdata_d = cfg_q & 8'h73;
				VLC_ADDR_XMIT: rdata_d = xc_q;
				VLC_ADDR_STATUS: begin
					rdata_d[VLC_ST_RATE_LOCK] = rate_lock_q;
					rdata_d[VLC_ST_RX_OK] = rx_ok_q;
					rdata_d[VLC_ST_TX_OK] = tx_ok_q;
					rdata_d[VLC_ST_TX_EMPTY] = engine_evt.set_tx_empty && !xc_q[VLC_XC_EOD];
				end
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_rate_locked: assert property (@(posedge ref_clk) disable iff (rst)
		rate_lock_q |=> $stable(cfg_q[5:4]))
		else $error("rate bits changed after lock");
	// Tick at divide by eight in an enabled cycle, then seven more enabled cycles
	sequence s_tick_run8;
		(tick_q && cfg_q[5:4] == 2'h3 && engine_clk_en) ##1 engine_clk_en [*7];
	endsequence
	chk_div_by_8: assert property (@(posedge ref_clk) disable iff (rst)
		s_tick_run8 |=> tick_q && !$past(tick_q))
		else $error("divide by eight spacing wrong");
	chk_irq_gate: assert property (@(posedge ref_clk) disable iff (rst)
		(!cfg_q[VLC_CFG_INT_EN] && !wake_request) |=> !irq_q)
		else $error("interrupt while disabled");
	chk_irq_hold: assert property (@(posedge ref_clk) disable iff (rst)
		(irq_sources && cfg_q[VLC_CFG_INT_EN]) |=> irq_q)
		else $error("interrupt dropped with source");
	chk_wait_gate: assert property (@(posedge ref_clk) disable iff (rst)
		(cpu_wait && cfg_q[VLC_CFG_WAIT_GATE]) |-> !engine_clk_en)
		else $error("clock runs in gated wait");
	chk_analog_loopback_nodrive: assert property (@(posedge ref_clk) disable iff (rst)
		xc_q[VLC_XC_ANALOG_LOOPBACK] |-> !bus_tx_oe && !ctrl.transmit_allowed)
		else $error("bus driven in loopback");
	chk_digital_loopback_echo: assert property (@(posedge ref_clk) disable iff (rst)
		xc_q[VLC_XC_DIGITAL_LOOPBACK] |=> digital_receive_in == $past(digital_transmit_out))
		else $error("loopback echo missing");
	chk_exit_idle: assert property (@(posedge ref_clk) disable iff (rst)
		loop_clear |=> !tx_ok_q)
		else $error("transmit allowed too early");
	chk_break_clear: assert property (@(posedge ref_clk) disable iff (rst)
		(engine_evt.break_rx && !wr_xc) |=> !xc_q[VLC_XC_FAST_RX] && sv_load)
		else $error("break handling wrong");
	chk_eod_err: assert property (@(posedge ref_clk) disable iff (rst)
		(engine_evt.error && !wr_xc) |=> !xc_q[VLC_XC_EOD])
		else $error("end of data not cleared");
	chk_ifr_prio: assert property (@(posedge ref_clk) disable iff (rst)
		xc_q[2:1] == 2'h3 |-> ctrl.ifr_kind == VLC_IFR_SINGLE)
		else $error("response priority wrong");

endmodule // vlc_link_ctrl

// ---- tb/vlc_xcvr_model.sv ----
/*
 * Model of the external bus transceiver facing the link control bank.
 * Assumes a passive-low bus held by a pull-down, and one other node
 * that the bench may drive active.
 */
`timescale 1ns/1ps

module vlc_xcvr_model (
	input wire logic tx_in,
	input wire logic tx_oe,
	input wire logic loop_en,
	input wire logic node_drive,
	output logic rx_out
);
	logic bus_level;

	// Wired-or bus; a released bus falls to the passive level
	assign bus_level = (tx_oe & tx_in) | node_drive;
	// Loopback returns the final-stage input and leaves the bus alone
	assign rx_out = loop_en ? tx_in : bus_level;
endmodule // vlc_xcvr_model

// ---- tb/vlc_link_ctrl_tb.sv ----
/*
 * Self-checking bench for the link control register bank.
 * Assumes the design package and short idle counts for simulation.
 */
`timescale 1ns/1ps

module vlc_link_ctrl_tb;
	import vlc_pkg::*;

	localparam int EOF_N = 20;
	localparam int IFS_N = 30;
	typedef struct packed {
		logic [7:0] wdata;
		vlc_ifr_t kind;
		logic nb_crc;
		logic nb_plain;
		logic fast;
	} vlc_row_t;

	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	vlc_evt_t evt = 6'h02;
	logic in_ifr = 1'b0;
	logic irq_sources = 1'b0;
	logic wake_request = 1'b0;
	logic cpu_wait = 1'b0;
	logic dtx = 1'b1;
	logic node_drive = 1'b0;
	logic xcvr_loop = 1'b1;
	logic bus_rx_pin, drx, tx_pin, tx_oe, tick, clk_en, irq_req, sv_load;
	logic [15:0] sv_val;
	vlc_ctrl_t ctrl;
	int fail_count = 0;
	int check_count = 0;
	int cycles = 0;
	int n;
	logic [7:0] rv;
	// Ordinary transmit-control writes and what they should set up
	vlc_row_t rows [8] = '{
		'{8'h00, VLC_IFR_NONE, 1'b1, 1'b0, 1'b0},
		'{8'h04, VLC_IFR_SINGLE, 1'b1, 1'b0, 1'b0},
		'{8'h07, VLC_IFR_SINGLE, 1'b1, 1'b0, 1'b0},
		'{8'h03, VLC_IFR_MULTI_CRC, 1'b1, 1'b0, 1'b0},
		'{8'h02, VLC_IFR_MULTI_CRC, 1'b1, 1'b0, 1'b0},
		'{8'h01, VLC_IFR_MULTI_PLAIN, 1'b1, 1'b0, 1'b0},
		'{8'h10, VLC_IFR_NONE, 1'b0, 1'b1, 1'b0},
		'{8'h35, VLC_IFR_SINGLE, 1'b0, 1'b1, 1'b1}
	};

	vlc_link_ctrl #(.EOF_CYCLES(EOF_N), .IFS_CYCLES(IFS_N)) uut (
		.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .engine_evt(evt),
		.in_ifr(in_ifr), .irq_sources(irq_sources), .wake_request(wake_request),
		.cpu_wait(cpu_wait), .digital_transmit_out(dtx), .bus_rx_pin(bus_rx_pin),
		.digital_receive_in(drx), .bus_tx_pin(tx_pin), .bus_tx_oe(tx_oe),
		.time_base_tick(tick), .engine_clk_en(clk_en), .irq_req(irq_req),
		.sv_load(sv_load), .sv_load_value(sv_val), .ctrl(ctrl)
	);

	vlc_xcvr_model xcvr (.tx_in(tx_pin), .tx_oe(tx_oe), .loop_en(xcvr_loop),
		.node_drive(node_drive), .rx_out(bus_rx_pin));

	// Clock and hang guard; the run needs about four hundred cycles
	initial forever #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 8000) begin
			fail_count++;
			summarize();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
	endtask

	// One-cycle strobes; a clock passes between calls so no signal is set twice
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic pulse(input int b);
		@(posedge ref_clk);
		evt[b] <= 1'b1;
		@(posedge ref_clk);
		evt[b] <= 1'b0;
	endtask

	task automatic settle(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		do_reset();
		rd(VLC_ADDR_CONFIG, rv);
		chk(16'(rv), 16'(VLC_CFG_RESET), "config reset");
		rd(VLC_ADDR_XMIT, rv);
		chk(16'(rv), 16'(VLC_XC_RESET), "xmit reset");
		chk(16'(tx_oe), 16'h0000, "oe in analog loop");
		// Digital loop must ignore the bus and follow transmit
		@(posedge ref_clk);
		dtx <= 1'b0;
		node_drive <= 1'b1;
		xcvr_loop <= 1'b0;
		settle(3);
		chk(16'(drx), 16'h0000, "digital loop");
		chk(16'(tx_oe), 16'h0000, "oe in analog loop");
		// Analog loop alone: transceiver echoes the pin, bus stays quiet
		dtx <= 1'b1;
		node_drive <= 1'b0;
		xcvr_loop <= 1'b1;
		wr(VLC_ADDR_XMIT, 8'h80);
		settle(4);
		chk(16'(drx), 16'h0001, "analog loop echo");
		chk(16'(tx_oe), 16'h0000, "oe off in analog loop");
		xcvr_loop <= 1'b0;
		wr(VLC_ADDR_XMIT, 8'h00);
		settle(EOF_N + 3);
		rd(VLC_ADDR_STATUS, rv);
		chk(16'(rv[2:1]), 16'h0001, "rx ready, tx waits");
		settle(10);
		rd(VLC_ADDR_STATUS, rv);
		chk(16'(rv[2:1]), 16'h0003, "both ready");
		chk(16'(tx_oe), 16'h0001, "oe driving");
		// Out of loopback the receiver follows the bus, not transmit
		dtx <= 1'b0;
		node_drive <= 1'b1;
		settle(4);
		chk(16'({drx, tx_pin}), 16'h0002, "bus to receiver");
		node_drive <= 1'b0;
		dtx <= 1'b1;
		settle(1);
		chk(16'(tx_pin), 16'h0001, "transmit to pin");
		$display("test reset and loopback done");

		foreach (rows[i]) begin
			wr(VLC_ADDR_XMIT, rows[i].wdata);
			rd(VLC_ADDR_XMIT, rv);
			chk(16'(rv), 16'(rows[i].wdata), "readback");
			chk(16'(ctrl.ifr_kind), 16'(rows[i].kind), "ifr kind");
			chk(16'({ctrl.normalization_bit_crc, ctrl.normalization_bit_plain}),
				16'({rows[i].nb_crc, rows[i].nb_plain}), "nb format");
			chk(16'(ctrl.fast_receive_only), 16'(rows[i].fast), "fast rx");
			chk(16'(ctrl.transmit_allowed), 16'(!rows[i].fast), "fast rx no tx");
		end
		$display("test row table done");

		// Each rate gets a fresh reset, since the field locks once written
		for (int r = 0; r < 4; r++) begin
			do_reset();
			wr(VLC_ADDR_CONFIG, 8'(r << 4) | 8'h40);
			#1;
			chk(16'(ctrl.time_base_select), 16'h0001, "time base");
			n = 0;
			repeat (48) begin
				settle(1);
				n += int'(tick);
			end
			chk(16'(n), 16'(48 >> r), "tick count");
			wr(VLC_ADDR_CONFIG, 8'h00);
			rd(VLC_ADDR_CONFIG, rv);
			chk(16'(rv), 16'(r << 4), "rate locked");
		end
		rd(4'hF, rv);
		chk(16'(rv), 16'h0000, "unmapped read");
		wr(4'hF, 8'hFF);
		rd(VLC_ADDR_CONFIG, rv);
		chk(16'(rv), 16'h0030, "unmapped write");
		$display("test rates done");

		wr(VLC_ADDR_CONFIG, 8'h02);
		irq_sources <= 1'b1;
		settle(2);
		chk(16'(irq_req), 16'h0001, "irq raised");
		settle(5);
		chk(16'(irq_req), 16'h0001, "irq held");
		irq_sources <= 1'b0;
		settle(2);
		chk(16'(irq_req), 16'h0000, "irq cleared");
		wr(VLC_ADDR_CONFIG, 8'h00);
		irq_sources <= 1'b1;
		settle(2);
		chk(16'(irq_req), 16'h0000, "irq masked");
		wake_request <= 1'b1;
		settle(2);
		chk(16'(irq_req), 16'h0001, "wake unmasked");
		wake_request <= 1'b0;
		irq_sources <= 1'b0;
		$display("test interrupts done");

		wr(VLC_ADDR_CONFIG, 8'h01);
		cpu_wait <= 1'b1;
		settle(2);
		chk(16'(clk_en), 16'h0000, "gated in wait");
		n = 0;
		repeat (16) begin
			settle(1);
			n += int'(tick);
		end
		chk(16'(n), 16'h0000, "no ticks gated");
		wr(VLC_ADDR_CONFIG, 8'h00);
		settle(1);
		chk(16'(clk_en), 16'h0001, "run in wait");
		cpu_wait <= 1'b0;
		$display("test wait gate done");

		wr(VLC_ADDR_XMIT, 8'h20);
		pulse(5);
		#1;
		chk(16'(sv_load), 16'h0001, "vector load");
		chk(sv_val, VLC_SV_BREAK, "vector value");
		settle(1);
		chk(16'(ctrl.fast_receive_only), 16'h0000, "fast rx cleared");
		$display("test break done");

		evt.set_tx_empty <= 1'b1;
		rd(VLC_ADDR_STATUS, rv);
		chk(16'(rv[3]), 16'h0001, "tx empty shown");
		wr(VLC_ADDR_XMIT, 8'h08);
		rd(VLC_ADDR_STATUS, rv);
		chk(16'(rv[3]), 16'h0000, "tx empty dropped");
		chk(16'(ctrl.end_of_data_request), 16'h0001, "eod to engine");
		pulse(4);
		rd(VLC_ADDR_XMIT, rv);
		chk(16'(rv), 16'h0000, "eod on crc bit");
		in_ifr <= 1'b1;
		wr(VLC_ADDR_XMIT, 8'h08);
		pulse(4);
		rd(VLC_ADDR_XMIT, rv);
		chk(16'(rv), 16'h0008, "eod kept in response");
		pulse(3);
		rd(VLC_ADDR_XMIT, rv);
		chk(16'(rv), 16'h0000, "eod on echoed eod");
		wr(VLC_ADDR_XMIT, 8'h08);
		pulse(2);
		rd(VLC_ADDR_XMIT, rv);
		chk(16'(rv), 16'h0000, "eod on error");
		$display("test end of data done");
		summarize();
	end
endmodule // vlc_link_ctrl_tb
